// ==== design/cmpo_pkg.sv ====
package cmpo_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_ADDR  = 12'h000;
	localparam logic [11:0] FLAGS_ADDR = 12'h004;
	localparam logic [11:0] EN_ADDR    = 12'h008;
	localparam logic [11:0] DIR_ADDR   = 12'h00c;
	localparam logic [11:0] PORT_ADDR  = 12'h010;
	localparam logic [11:0] ISTAT_ADDR = 12'h014;
	localparam logic [11:0] IMASK_ADDR = 12'h018;
	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_RES2   = 7;
	localparam int CTRL_RES1   = 6;
	localparam int CTRL_INV2   = 5;
	localparam int CTRL_INV1   = 4;
	localparam int CTRL_ROUTE  = 3;
	localparam int CTRL_SEL_HI = 2;
	localparam logic [7:0] CTRL_RESET = 8'h07;
	localparam logic [2:0] SEL_INT_REF = 3'h6;
	localparam logic [7:0] DIR_RESET = 8'hff;
	// ----------------------------------------------------------------
	// enable fields and routed pin numbers
	// ----------------------------------------------------------------
	localparam int EN_CHANGE = 0;
	localparam int EN_PERIPH = 1;
	localparam int EN_GLOBAL = 2;
	localparam int PIN_FIVE  = 5;
	localparam int PIN_FOUR  = 4;
endpackage : cmpo_pkg

// ==== design/cmpo_top.sv ====
// How it works
// - result high when plus input above minus input, else low
// - selector 110 feeds internal reference to both plus inputs
// - both results read-only in control register bits 7:6
// - routing drives pins four and five with unsynchronised results after the invert bits
// - direction bits still gate each routed pin's output driver
// - invert bits 5 and 4 flip each comparator's result
// - change flag sets on a result mismatch except during a control register access, enables ignored
// - writing zero clears change flag, writing one sets it
// - interrupt needs flag, own enable, peripheral and global enable
// - change coinciding with control read may be missed
// - any control register access refreshes the recorded copy
// - persisting mismatch keeps setting flag; access control before clearing
// - port read returns zero for analog-configured pins
module cmpo_top
	import cmpo_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [11:0]       PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic              CMP1_PLUS_GT,
	input  wire logic              CMP2_PLUS_GT,
	input  wire logic              CMP1_EXT_GT,
	input  wire logic              CMP2_EXT_GT,
	input  wire logic [PORT_W-1:0] PIN_IN,
	input  wire logic [PORT_W-1:0] PIN_ANALOG,
	input  wire logic [PORT_W-1:0] PORT_OUT_LAT,
	output logic      [PORT_W-1:0] PIN_OUT,
	output logic      [PORT_W-1:0] PIN_OE,
	output logic      [2:0]        CONFIG_SEL,
	output logic                   IRQ
);
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire logic acc      = PSEL & PENABLE;
	wire logic wr       = acc & PWRITE;
	wire logic hit_ctrl = PADDR == CTRL_ADDR;
	wire logic hit_flg  = PADDR == FLAGS_ADDR;
	wire logic hit_en   = PADDR == EN_ADDR;
	wire logic hit_dir  = PADDR == DIR_ADDR;
	wire logic hit_port = PADDR == PORT_ADDR;
	wire logic hit_ist  = PADDR == ISTAT_ADDR;
	wire logic hit_imk  = PADDR == IMASK_ADDR;
	wire logic mapped   = hit_ctrl | hit_flg | hit_en | hit_dir | hit_port | hit_ist | hit_imk;

	logic [7:0]        ctrl_reg;
	logic [1:0]        copy_reg;
	logic              flag_reg;
	logic [2:0]        en_reg;
	logic [PORT_W-1:0] dir_reg;
	logic              ist_reg;
	logic              imk_reg;

	// ----------------------------------------------------------------
	// comparator results
	// ----------------------------------------------------------------
	// both comparator inputs are pre-resolved; selector picks internal-ref result
	wire logic int_ref = ctrl_reg[CTRL_SEL_HI:0] == SEL_INT_REF;
	wire logic raw1    = int_ref ? CMP1_PLUS_GT : CMP1_EXT_GT;
	wire logic raw2    = int_ref ? CMP2_PLUS_GT : CMP2_EXT_GT;
	wire logic [1:0] live = {raw2 ^ ctrl_reg[CTRL_INV2], raw1 ^ ctrl_reg[CTRL_INV1]};
	wire logic mismatch = live != copy_reg;
	wire logic ctrl_acc = acc & hit_ctrl;
	// mismatch during a control access is dropped: the copy is refreshed instead
	wire logic set_flag = mismatch & ~ctrl_acc;
	wire logic flag_wr  = wr & hit_flg;

	assign CONFIG_SEL = ctrl_reg[CTRL_SEL_HI:0];

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	wire logic route = ctrl_reg[CTRL_ROUTE];
	always_comb begin
		PIN_OUT = PORT_OUT_LAT;
		if (route) begin
			PIN_OUT[PIN_FOUR] = live[0];
			PIN_OUT[PIN_FIVE] = live[1];
		end
		PIN_OE = ~dir_reg;
	end
	wire logic [PORT_W-1:0] port_rd = PIN_IN & ~PIN_ANALOG;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	wire logic [7:0] ctrl_next = {live, PWDATA[CTRL_INV2:0]};
	wire logic flag_next = set_flag | (flag_wr ? PWDATA[0] : flag_reg);
	wire logic irq_src = flag_reg & en_reg[EN_CHANGE] & en_reg[EN_PERIPH] & en_reg[EN_GLOBAL];
	wire logic ist_next = irq_src | (ist_reg & ~(wr & hit_ist & PWDATA[0]));

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= CTRL_RESET;
			copy_reg <= '0;
			flag_reg <= 1'b0;
			en_reg   <= '0;
			dir_reg  <= DIR_RESET[PORT_W-1:0];
			ist_reg  <= 1'b0;
			imk_reg  <= 1'b0;
		end else begin
			ctrl_reg <= (wr & hit_ctrl) ? ctrl_next : {live, ctrl_reg[CTRL_INV2:0]};
			if (ctrl_acc)
				copy_reg <= live;
			flag_reg <= flag_next;
			if (wr & hit_en)
				en_reg <= PWDATA[2:0];
			if (wr & hit_dir)
				dir_reg <= PWDATA[PORT_W-1:0];
			ist_reg <= ist_next;
			if (wr & hit_imk)
				imk_reg <= PWDATA[0];
		end
	end

	assign IRQ = ist_reg & imk_reg;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	wire logic [31:0] rd_ctrl = {24'h0, live, ctrl_reg[CTRL_INV2:0]};
	wire logic [31:0] rd_port = {{(32-PORT_W){1'b0}}, port_rd};
	wire logic [31:0] rd_dir  = {{(32-PORT_W){1'b0}}, dir_reg};
	assign PRDATA = hit_ctrl ? rd_ctrl :
		hit_flg ? {31'h0, flag_reg} :
		hit_en ? {29'h0, en_reg} :
		hit_dir ? rd_dir :
		hit_port ? rd_port :
		hit_ist ? {31'h0, ist_reg} :
		hit_imk ? {31'h0, imk_reg} : 32'h0;
	assign PREADY  = 1'b1;
	assign PSLVERR = acc & ~mapped;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// change flag: set wins over a software clear while a mismatch persists
	chk_flag_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		mismatch && !ctrl_acc |=> flag_reg)
		else $error("flag not set");

	chk_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		flag_wr && !PWDATA[0] && !set_flag |=> !flag_reg)
		else $error("clear failed");

	chk_flag_swset: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		flag_wr && PWDATA[0] |=> flag_reg)
		else $error("soft set failed");

	chk_flag_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!mismatch && !flag_wr |=> flag_reg == $past(flag_reg))
		else $error("flag moved");

	chk_flag_drop: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		mismatch && ctrl_acc && !flag_wr && !flag_reg |=> !flag_reg)
		else $error("dropped event set flag");

	chk_mis_persist: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		mismatch && !ctrl_acc && flag_wr && !PWDATA[0] |=> flag_reg)
		else $error("clear beat mismatch");

	// recorded copy only moves on a control access
	chk_copy_upd: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		ctrl_acc |=> copy_reg == $past(live))
		else $error("copy stale");

	chk_copy_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!ctrl_acc |=> $stable(copy_reg))
		else $error("copy moved");

	chk_mis_ends: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		ctrl_acc ##1 $stable(live) |-> !mismatch)
		else $error("mismatch survived access");

	// result selection and polarity
	chk_sel_int: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		int_ref |-> raw1 == CMP1_PLUS_GT && raw2 == CMP2_PLUS_GT)
		else $error("internal ref not used");

	chk_sel_ext: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!int_ref |-> raw1 == CMP1_EXT_GT && raw2 == CMP2_EXT_GT)
		else $error("external input not used");

	chk_inv_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		ctrl_reg[CTRL_INV1] |-> live[0] != raw1)
		else $error("first not inverted");

	chk_inv_second: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		ctrl_reg[CTRL_INV2] |-> live[1] != raw2)
		else $error("second not inverted");

	chk_plain_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!ctrl_reg[CTRL_INV1] |-> live[0] == raw1)
		else $error("first polarity wrong");

	chk_plain_second: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!ctrl_reg[CTRL_INV2] |-> live[1] == raw2)
		else $error("second polarity wrong");

	chk_cfg_out: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		CONFIG_SEL == ctrl_reg[CTRL_SEL_HI:0])
		else $error("selector output wrong");

	// control register contents
	chk_ro_result: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr && hit_ctrl |=> ctrl_reg[CTRL_RES2:CTRL_RES1] == $past(live))
		else $error("ro bits");

	chk_ctrl_rd_res: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc && hit_ctrl |-> PRDATA[CTRL_RES2:CTRL_RES1] == live)
		else $error("result read wrong");

	chk_ctrl_wr_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr && hit_ctrl |=> ctrl_reg[CTRL_INV2:0] == $past(PWDATA[CTRL_INV2:0]))
		else $error("control write lost");

	chk_ctrl_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!(wr && hit_ctrl) |=> $stable(ctrl_reg[CTRL_INV2:0]))
		else $error("control bits moved");

	// pins: routed bits bypass the clock on purpose, so glitches reach the pad
	chk_route_pin: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		route |-> PIN_OUT[PIN_FOUR] == live[0] && PIN_OUT[PIN_FIVE] == live[1])
		else $error("route wrong");

	chk_route_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!route |-> PIN_OUT == PORT_OUT_LAT)
		else $error("latch not on pins");

	chk_dir_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		PIN_OE == ~dir_reg)
		else $error("oe wrong");

	chk_dir_wr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr && hit_dir |=> dir_reg == $past(PWDATA[PORT_W-1:0]))
		else $error("direction write lost");

	chk_analog_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc && hit_port |-> (PRDATA[PORT_W-1:0] & PIN_ANALOG) == '0)
		else $error("analog read");

	chk_port_digital: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc && hit_port |-> PRDATA[PORT_W-1:0] == (PIN_IN & ~PIN_ANALOG))
		else $error("digital read wrong");

	// interrupt path
	chk_irq_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		irq_src |=> ist_reg)
		else $error("irq lost");

	chk_irq_needs: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(ist_reg) |-> $past(irq_src))
		else $error("irq without enables");

	chk_irq_none: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		!irq_src && !ist_reg |=> !ist_reg)
		else $error("spurious status");

	chk_ist_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr && hit_ist && PWDATA[0] && !irq_src |=> !ist_reg)
		else $error("status not cleared");

	chk_en_wr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		wr && hit_en |=> en_reg == $past(PWDATA[2:0]))
		else $error("enable write lost");

	chk_irq_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		IRQ == (ist_reg && imk_reg))
		else $error("irq level wrong");

	// bus error reporting
	chk_unmapped_err: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc && !mapped |-> PSLVERR && PRDATA == '0)
		else $error("unmapped not refused");

	chk_mapped_ok: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		acc && mapped |-> !PSLVERR)
		else $error("mapped refused");

	cov_change: cover property (@(posedge SYS_CLK) disable iff (!RST_N) mismatch ##1 flag_reg);
	cov_swset: cover property (@(posedge SYS_CLK) disable iff (!RST_N) flag_wr && PWDATA[0] && !flag_reg);
	cov_service: cover property (@(posedge SYS_CLK) disable iff (!RST_N) ctrl_acc ##[1:4] flag_wr);
	cov_irq: cover property (@(posedge SYS_CLK) disable iff (!RST_N) IRQ);
	cov_intref: cover property (@(posedge SYS_CLK) disable iff (!RST_N) int_ref && route);
endmodule : cmpo_top

// ==== sim/tb_cmpo_top.sv ====
module tb_cmpo_top import cmpo_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
	logic        c1p, c2p, c1e, c2e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  pin_in, pin_an, lat, pin_out, pin_oe;
	logic [2:0]  cfg;
	int          bad_count, checked;
	cmpo_top dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CMP1_PLUS_GT(c1p), .CMP2_PLUS_GT(c2p), .CMP1_EXT_GT(c1e),
		.CMP2_EXT_GT(c2e), .PIN_IN(pin_in), .PIN_ANALOG(pin_an), .PORT_OUT_LAT(lat),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .CONFIG_SEL(cfg), .IRQ(irq));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	// one idle edge ahead so a release and a new setup never share a step
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin bad_count++; conclude(); end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : wt
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		c1p = 0; c2p = 0; c1e = 0; c2e = 0; pin_in = 8'hff; pin_an = 8'h0f; lat = 8'h00;
		bad_count = 0; checked = 0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		rdc(CTRL_ADDR, 32'h07);
		rdc(DIR_ADDR, 32'hff);
		apb(1'b1, CTRL_ADDR, 32'hce);
		rdc(CTRL_ADDR, 32'h0e);
		chk(32'(cfg), 32'h6);
		$display("reset and read-only test done");
		@(posedge sys_clk); c1p <= 1'b1;
		wt(2);
		apb(1'b1, FLAGS_ADDR, 32'h0);
		rdc(FLAGS_ADDR, 32'h1);
		@(posedge sys_clk); c2e <= 1'b1;
		rdc(CTRL_ADDR, 32'h4e);
		apb(1'b1, FLAGS_ADDR, 32'h0);
		rdc(FLAGS_ADDR, 32'h0);
		apb(1'b1, CTRL_ADDR, 32'h08);
		rdc(CTRL_ADDR, 32'h88);
		apb(1'b1, CTRL_ADDR, 32'h3e);
		rdc(CTRL_ADDR, 32'hbe);
		$display("result and change test done");
		apb(1'b1, DIR_ADDR, 32'h0);
		wt(0);
		chk(32'(pin_out & 8'h30), 32'h20);
		chk(32'(pin_oe), 32'hff);
		apb(1'b1, DIR_ADDR, 32'hef);
		@(posedge sys_clk); c1p <= 1'b0;
		wt(0);
		chk(32'(pin_oe), 32'h10);
		chk(32'(pin_out & 8'h30), 32'h30);
		$display("pin routing test done");
		apb(1'b0, CTRL_ADDR, 32'h0);
		apb(1'b1, EN_ADDR, 32'h3);
		apb(1'b1, FLAGS_ADDR, 32'h0);
		rdc(FLAGS_ADDR, 32'h0);
		apb(1'b1, FLAGS_ADDR, 32'h1);
		wt(3);
		rdc(FLAGS_ADDR, 32'h1);
		rdc(ISTAT_ADDR, 32'h0);
		apb(1'b1, IMASK_ADDR, 32'h1);
		apb(1'b1, EN_ADDR, 32'h7);
		wt(3);
		chk(32'(irq), 32'h1);
		apb(1'b1, EN_ADDR, 32'h3);
		apb(1'b1, ISTAT_ADDR, 32'h1);
		wt(3);
		chk(32'(irq), 32'h0);
		$display("interrupt test done");
		rdc(PORT_ADDR, 32'hf0);
		chk(32'(err), 32'h0);
		@(posedge sys_clk); lat <= 8'h5a;
		apb(1'b1, CTRL_ADDR, 32'h07);
		wt(0);
		chk(32'(pin_out), 32'h5a);
		rdc(12'h100, 32'h0);
		chk(32'(err), 32'h1);
		$display("port and unmapped test done");
		conclude();
	end
endmodule : tb_cmpo_top
